//--- hdl/pscp_pkg.sv
// shared constants and types of the paged serial configuration port
package pscp_pkg;

	// register map
	localparam logic [6:0] ADDR_PAGE     = 7'h64;
	localparam logic [6:0] ADDR_PAGED_LO = 7'h65;
	localparam logic [6:0] ADDR_DYN_LO   = 7'h00;
	localparam logic [6:0] ADDR_DYN_HI   = 7'h01;
	localparam logic [3:0] PAGE_USED     = 4'hD;
	localparam logic [7:0] PAGE_RST      = 8'h00;

	// low-byte addresses of two-byte registers
	localparam int         MB_PAIRS          = 4;
	localparam logic [6:0] MB_LO [0:MB_PAIRS-1] =
		'{7'h38, 7'h40, 7'h45, 7'h4A};

	// frame bit counts
	localparam logic [3:0] BIT_ADDR_END = 4'h7;
	localparam logic [3:0] BIT_LAST     = 4'hF;

	// pin sampler reset value, order {cs_n, sck, si}
	localparam logic [2:0] PIN_RST = 3'h4;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ADDR = 4'h2,
		ST_DATA = 4'h4,
		ST_HOLD = 4'h8
	} pscp_state_t;

	typedef struct packed {
		logic [3:0]  page;
		logic [6:0]  addr;
		logic [15:0] data;
	} pscp_wr_t;

	function automatic logic pscp_mb_lo(input logic [6:0] a);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < MB_PAIRS; i++)
			if (a == MB_LO[i])
				hit = 1'b1;
		return hit;
	endfunction : pscp_mb_lo

	function automatic logic pscp_mb_hi(input logic [6:0] a);
		return pscp_mb_lo(a - 7'h01);
	endfunction : pscp_mb_hi

endpackage : pscp_pkg

//--- hdl/pscp_port.sv
// serial register port with bit order strap and page pointer
`timescale 1ns/1ps
module pscp_port
	import pscp_pkg::*;
#(
	parameter logic RD_CMD = 1'b1
)(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// serial pins
	input  wire logic        cs_n,
	input  wire logic        sck,
	input  wire logic        si,
	output      logic        so,
	output      logic        so_oe_n,
	// device core side
	input  wire logic [15:0] dyn_value,
	output      logic        cfg_wr_stb,
	output      pscp_wr_t    cfg_wr,
	output      logic [7:0]  page_select
);

	logic [2:0]  pin_s1;
	logic [2:0]  pin_s2;
	logic [2:0]  pin_s3;
	logic [2:0]  pin_f;
	logic [2:0]  pin_q;
	logic [2:0]  next_pin_f;
	logic        cs_act;
	logic        cs_fall;
	logic        sck_f;
	logic        sck_rise;
	logic        si_f;

	pscp_state_t st;
	pscp_state_t next_st;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic        msb_first;
	logic        next_msb_first;
	logic        is_rd;
	logic        next_is_rd;
	logic [6:0]  addr;
	logic [6:0]  next_addr;
	logic [7:0]  in_sh;
	logic [7:0]  next_in_sh;
	logic [7:0]  out_sh;
	logic [7:0]  next_out_sh;
	logic        next_so;
	logic [7:0]  mb_buf;
	logic [7:0]  next_mb_buf;
	logic [7:0]  dyn_snap;
	logic [7:0]  next_dyn_snap;
	logic [7:0]  next_page_select;
	logic        next_cfg_wr_stb;
	pscp_wr_t    next_cfg_wr;

	logic [7:0]  sh_new;
	logic [6:0]  addr_new;
	logic        cmd_new;
	logic [7:0]  rd_val;
	logic        dmem_we;
	logic        pair_we;
	logic        pmem_we;
	logic [8:0]  pidx_rd;
	logic [8:0]  pidx_wr;

	logic [7:0]  dmem [0:100];
	logic [7:0]  pmem [0:511];

	// pin sampler: three flops, change taken when 2nd and 3rd agree
	always_comb
	begin
		next_pin_f = ((pin_s2 ~^ pin_s3) & pin_s3)
			| ((pin_s2 ^ pin_s3) & pin_f);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pin_s1 <= PIN_RST;
			pin_s2 <= PIN_RST;
			pin_s3 <= PIN_RST;
			pin_f  <= PIN_RST;
			pin_q  <= PIN_RST;
		end
		else
		begin
			pin_s1 <= {cs_n, sck, si};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= next_pin_f;
			pin_q  <= pin_f;
		end
	end

	assign cs_act   = ~pin_f[2];
	assign cs_fall  = pin_q[2] & ~pin_f[2];
	assign sck_f    = pin_f[1];
	assign sck_rise = ~pin_q[1] & pin_f[1];
	assign si_f     = pin_f[0];

	// incoming bit placed by the chosen order
	always_comb
	begin
		sh_new = msb_first ? {in_sh[6:0], si_f}
			: {si_f, in_sh[7:1]};
		addr_new = msb_first ? sh_new[6:0] : sh_new[7:1];
		cmd_new  = msb_first ? sh_new[7] : sh_new[0];
	end

	// read data selection for the address just received
	always_comb
	begin
		pidx_rd = {page_select[3:0], 5'(addr_new - ADDR_PAGED_LO)};
		if (addr_new == ADDR_PAGE)
			rd_val = page_select;
		else if (addr_new == ADDR_DYN_LO)
			rd_val = dyn_value[7:0];
		else if (addr_new == ADDR_DYN_HI)
			rd_val = dyn_snap;
		else if (addr_new < ADDR_PAGED_LO)
			rd_val = dmem[addr_new];
		else if (page_select[3:0] < PAGE_USED)
			rd_val = pmem[pidx_rd];
		else
			rd_val = 8'h00;
	end

	// frame control
	always_comb
	begin
		next_st          = st;
		next_bit_cnt     = bit_cnt;
		next_msb_first   = msb_first;
		next_is_rd       = is_rd;
		next_addr        = addr;
		next_in_sh       = in_sh;
		next_out_sh      = out_sh;
		next_so          = so;
		next_mb_buf      = mb_buf;
		next_dyn_snap    = dyn_snap;
		next_page_select = page_select;
		next_cfg_wr_stb  = 1'b0;
		next_cfg_wr      = cfg_wr;
		dmem_we          = 1'b0;
		pair_we          = 1'b0;
		pmem_we          = 1'b0;
		if (!cs_act)
			next_st = ST_IDLE;
		else
		begin
			case (st)
			ST_IDLE:
			begin
				if (cs_fall)
				begin
					next_st        = ST_ADDR;
					next_bit_cnt   = 4'h0;
					next_is_rd     = 1'b0;
					next_msb_first = ~sck_f;
				end
			end
			ST_ADDR:
			begin
				if (sck_rise)
				begin
					next_in_sh   = sh_new;
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == BIT_ADDR_END)
					begin
						next_st    = ST_DATA;
						next_addr  = addr_new;
						next_is_rd = (cmd_new == RD_CMD);
						if (cmd_new == RD_CMD)
						begin
							// first data bit out at once
							next_so = msb_first ? rd_val[7]
								: rd_val[0];
							next_out_sh = msb_first
								? {rd_val[6:0], 1'b0}
								: {1'b0, rd_val[7:1]};
							if (addr_new == ADDR_DYN_LO)
								next_dyn_snap = dyn_value[15:8];
						end
					end
				end
			end
			ST_DATA:
			begin
				if (sck_rise)
				begin
					next_bit_cnt = bit_cnt + 4'h1;
					if (is_rd)
					begin
						next_so = msb_first ? out_sh[7]
							: out_sh[0];
						next_out_sh = msb_first
							? {out_sh[6:0], 1'b0}
							: {1'b0, out_sh[7:1]};
					end
					else
						next_in_sh = sh_new;
					if (bit_cnt == BIT_LAST)
					begin
						next_st = ST_HOLD;
						if (!is_rd)
						begin
							next_cfg_wr.page = page_select[3:0];
							next_cfg_wr.addr = addr;
							next_cfg_wr.data = {8'h00, sh_new};
							if (addr >= ADDR_PAGED_LO)
							begin
								// unused pages drop writes
								pmem_we = page_select[3:0]
									< PAGE_USED;
								next_cfg_wr_stb = pmem_we;
							end
							else if (pscp_mb_lo(addr))
								next_mb_buf = sh_new;
							else
							begin
								dmem_we = 1'b1;
								next_cfg_wr_stb = 1'b1;
								if (addr == ADDR_PAGE)
									next_page_select = sh_new;
								if (pscp_mb_hi(addr))
								begin
									pair_we = 1'b1;
									next_cfg_wr.data = {mb_buf,
										sh_new};
								end
							end
						end
					end
				end
			end
			ST_HOLD:
			begin
				next_st = ST_HOLD;
			end
			default:
			begin
				next_st = ST_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st          <= ST_IDLE;
			bit_cnt     <= 4'h0;
			msb_first   <= 1'b1;
			is_rd       <= 1'b0;
			addr        <= 7'h00;
			in_sh       <= 8'h00;
			out_sh      <= 8'h00;
			so          <= 1'b0;
			mb_buf      <= 8'h00;
			dyn_snap    <= 8'h00;
			page_select <= PAGE_RST;
			cfg_wr_stb  <= 1'b0;
			cfg_wr      <= '0;
		end
		else
		begin
			st          <= next_st;
			bit_cnt     <= next_bit_cnt;
			msb_first   <= next_msb_first;
			is_rd       <= next_is_rd;
			addr        <= next_addr;
			in_sh       <= next_in_sh;
			out_sh      <= next_out_sh;
			so          <= next_so;
			mb_buf      <= next_mb_buf;
			dyn_snap    <= next_dyn_snap;
			page_select <= next_page_select;
			cfg_wr_stb  <= next_cfg_wr_stb;
			cfg_wr      <= next_cfg_wr;
		end
	end

	// register storage
	assign pidx_wr = {page_select[3:0], 5'(addr - ADDR_PAGED_LO)};

	always_ff @(posedge clk)
	begin
		if (dmem_we)
			dmem[addr] <= sh_new;
		if (pair_we)
			dmem[addr - 7'h01] <= mb_buf;
		if (pmem_we)
			pmem[pidx_wr] <= sh_new;
	end

	// output driven in the data part of a read and in the hold after it, until deselect
	assign so_oe_n = ~(cs_act & is_rd
		& ((st == ST_DATA) | (st == ST_HOLD)));

	// checks
	property p_order_msb;
		@(posedge clk) disable iff (sys_rst)
		(st == ST_IDLE && cs_act && cs_fall && !sck_f)
			|=> msb_first;
	endproperty
	a_order_msb: assert property (p_order_msb)
		else $error("msb order not taken");

	property p_order_lsb;
		@(posedge clk) disable iff (sys_rst)
		(st == ST_IDLE && cs_act && cs_fall && sck_f)
			|=> !msb_first;
	endproperty
	a_order_lsb: assert property (p_order_lsb)
		else $error("lsb order not taken");

	property p_wr_full_frame;
		@(posedge clk) disable iff (sys_rst)
		cfg_wr_stb |-> $past(bit_cnt) == BIT_LAST
			&& $past(sck_rise) && $past(cs_act);
	endproperty
	a_wr_full_frame: assert property (p_wr_full_frame)
		else $error("write without full frame");

	property p_no_wr_on_read;
		@(posedge clk) disable iff (sys_rst)
		cfg_wr_stb |-> !$past(is_rd);
	endproperty
	a_no_wr_on_read: assert property (p_no_wr_on_read)
		else $error("write strobe during read");

	property p_oe_quiet;
		@(posedge clk) disable iff (sys_rst)
		!cs_act |-> so_oe_n;
	endproperty
	a_oe_quiet: assert property (p_oe_quiet)
		else $error("output driven while deselected");

	property p_oe_read_only;
		@(posedge clk) disable iff (sys_rst)
		!so_oe_n |-> is_rd && st != ST_ADDR;
	endproperty
	a_oe_read_only: assert property (p_oe_read_only)
		else $error("output driven outside read data");

	property p_page_kept;
		@(posedge clk) disable iff (sys_rst)
		!$stable(page_select) |-> cfg_wr_stb
			&& cfg_wr.addr == ADDR_PAGE
			&& cfg_wr.data[7:0] == page_select;
	endproperty
	a_page_kept: assert property (p_page_kept)
		else $error("page pointer changed without write");

	property p_hold_after_16;
		@(posedge clk) disable iff (sys_rst)
		(st == ST_DATA) ##1 (st == ST_HOLD)
			|-> $past(bit_cnt) == BIT_LAST;
	endproperty
	a_hold_after_16: assert property (p_hold_after_16)
		else $error("frame ended at wrong bit count");

	property p_mb_lo_quiet;
		@(posedge clk) disable iff (sys_rst)
		cfg_wr_stb |-> !pscp_mb_lo(cfg_wr.addr);
	endproperty
	a_mb_lo_quiet: assert property (p_mb_lo_quiet)
		else $error("low byte committed alone");

	property p_paged_used;
		@(posedge clk) disable iff (sys_rst)
		(cfg_wr_stb && cfg_wr.addr >= ADDR_PAGED_LO)
			|-> cfg_wr.page < PAGE_USED;
	endproperty
	a_paged_used: assert property (p_paged_used)
		else $error("write to unused page");

	c_read: cover property (@(posedge clk) disable iff (sys_rst)
		st == ST_DATA && is_rd ##1 st == ST_HOLD);
	c_write_lsb: cover property (@(posedge clk) disable iff (sys_rst)
		cfg_wr_stb && !msb_first);
	c_page_write: cover property (@(posedge clk) disable iff (sys_rst)
		cfg_wr_stb && cfg_wr.addr == ADDR_PAGE);
	c_paged_write: cover property (@(posedge clk)
		disable iff (sys_rst)
		cfg_wr_stb && cfg_wr.addr >= ADDR_PAGED_LO);

endmodule : pscp_port

//--- tb/pscp_host_model.sv
// host-side serial master model for the configuration port
`timescale 1ns/1ps
module pscp_host_model (
	// serial pins
	output logic cs_n,
	output logic sck,
	output logic si,
	input  logic so
);
	initial
	begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	// one frame; sck set to the order strap level before cs_n falls and held there 800 ns after it
	task automatic xfer(input logic lsb, input logic sel, input logic rd,
		input logic [6:0] a, input logic [7:0] d, input int n,
		output logic [7:0] q);
		logic [15:0] s;
		s[15] = rd;
		for (int i = 0; i < 7; i++)
			s[14-i] = lsb ? a[i] : a[6-i];
		for (int i = 0; i < 8; i++)
			s[7-i] = lsb ? d[i] : d[7-i];
		q = 8'h00;
		sck = lsb;
		#800 cs_n = ~sel;
		#800;
		for (int b = 0; b < n; b++)
		begin
			sck = 1'b0;
			// toggling junk on si during read data
			si = (rd && b > 7) ? b[0] : s[15-b];
			#400 sck = 1'b1;
			if (rd && b > 7)
				q[lsb ? b-8 : 15-b] = so;
			#400;
		end
		cs_n = 1'b1;
		si   = ~si;
		#1200;
	endtask : xfer
endmodule : pscp_host_model

//--- tb/pscp_port_tb_top.sv
// self-checking bench of the paged serial configuration port
`timescale 1ns/1ps
module pscp_port_tb_top;
	import pscp_pkg::*;
	logic        clk, sys_rst, cs_n, sck, si, so, so_oe_n;
	logic        cfg_wr_stb;
	logic [15:0] dyn_value;
	pscp_wr_t    cfg_wr, last_wr;
	logic [7:0]  page_select, q;
	int          err_count, samples_checked, n_stb, exp_stb, n_oe;

	pscp_port #(.RD_CMD(1'b1)) pscp_port_inst (
		.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .si(si),
		.so(so), .so_oe_n(so_oe_n), .dyn_value(dyn_value),
		.cfg_wr_stb(cfg_wr_stb), .cfg_wr(cfg_wr),
		.page_select(page_select));

	pscp_host_model pscp_host_model_inst (
		.cs_n(cs_n), .sck(sck), .si(si), .so(so));

	always #50 clk = ~clk;

	// strobe and output-enable monitor, sampled between edges
	always @(negedge clk)
	begin
		if (cfg_wr_stb === 1'b1)
		begin
			n_stb++;
			last_wr = cfg_wr;
		end
		if (so_oe_n === 1'b0)
			n_oe++;
	end

	task automatic chk(input logic [26:0] got, input logic [26:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic xact(input logic lsb, input logic sel, input logic rd,
		input logic [6:0] a, input logic [7:0] d, input int n);
		pscp_host_model_inst.xfer(lsb, sel, rd, a, d, n, q);
		@(negedge clk);
	endtask : xact

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	task automatic t_reset;
		chk(page_select, PAGE_RST);
		chk(so_oe_n, 1'b1);
		chk(cfg_wr_stb, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_order;
		xact(1'b0, 1'b1, 1'b0, 7'h10, 8'h5A, 16);
		exp_stb++;
		chk(n_stb, exp_stb);
		chk(last_wr, {4'h0, 7'h10, 16'h005A});
		xact(1'b1, 1'b1, 1'b0, 7'h11, 8'hA5, 16);
		exp_stb++;
		chk(n_stb, exp_stb);
		chk(last_wr, {4'h0, 7'h11, 16'h00A5});
		chk(so_oe_n, 1'b1);
		chk(n_oe, 0);
		$display("test order done");
	endtask : t_order

	task automatic t_page;
		xact(1'b0, 1'b1, 1'b0, ADDR_PAGE, 8'h0C, 16);
		exp_stb++;
		chk(page_select, 8'h0C);
		xact(1'b1, 1'b1, 1'b0, ADDR_PAGED_LO, 8'h77, 16);
		exp_stb++;
		chk(last_wr, {4'hC, ADDR_PAGED_LO, 16'h0077});
		xact(1'b0, 1'b1, 1'b0, 7'h7F, 8'h3C, 16);
		exp_stb++;
		chk(last_wr, {4'hC, 7'h7F, 16'h003C});
		xact(1'b0, 1'b1, 1'b0, ADDR_PAGE, {4'h0, PAGE_USED}, 16);
		exp_stb++;
		xact(1'b0, 1'b1, 1'b0, 7'h70, 8'h11, 16);
		chk(n_stb, exp_stb);
		xact(1'b0, 1'b1, 1'b0, 7'h20, 8'h42, 16);
		exp_stb++;
		chk({last_wr.addr, last_wr.data}, {7'h20, 16'h0042});
		$display("test page done");
	endtask : t_page

	task automatic t_abort;
		xact(1'b0, 1'b1, 1'b0, 7'h12, 8'hFF, 10);
		chk(n_stb, exp_stb);
		xact(1'b0, 1'b0, 1'b0, 7'h12, 8'hFF, 16);
		chk(n_stb, exp_stb);
		chk(so_oe_n, 1'b1);
		$display("test abort done");
	endtask : t_abort

	task automatic t_pair;
		xact(1'b0, 1'b1, 1'b0, 7'h38, 8'h12, 16);
		chk(n_stb, exp_stb);
		xact(1'b1, 1'b1, 1'b0, 7'h39, 8'h34, 16);
		exp_stb++;
		chk(n_stb, exp_stb);
		chk(last_wr.data, 16'h1234);
		chk(n_oe, 0);
		$display("test pair done");
	endtask : t_pair

	task automatic t_read;
		dyn_value = 16'hC33C;
		xact(1'b0, 1'b1, 1'b1, ADDR_DYN_LO, 8'h00, 16);
		chk(q, 8'h3C);
		dyn_value = 16'h0FF0;
		xact(1'b1, 1'b1, 1'b1, ADDR_DYN_HI, 8'h00, 16);
		chk(q, 8'hC3);
		xact(1'b1, 1'b1, 1'b1, ADDR_PAGE, 8'hFF, 16);
		chk(q, {4'h0, PAGE_USED});
		chk(n_stb, exp_stb);
		chk(n_oe != 0, 1'b1);
		$display("test read done");
	endtask : t_read

	initial
	begin
		#1000000;
		err_count++;
		close_out();
	end

	initial
	begin
		clk = 1'b0;
		sys_rst = 1'b1;
		dyn_value = 16'h0000;
		err_count = 0;
		samples_checked = 0;
		n_stb = 0;
		exp_stb = 0;
		n_oe = 0;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_order();
		t_page();
		t_abort();
		t_pair();
		t_read();
		close_out();
	end
endmodule : pscp_port_tb_top
